// ==== src/page_stack_pkg.sv ====
package page_stack_pkg;

    localparam int PAGE_W = 8;
    localparam int ADDR_W = 8;

    // Page values
    localparam logic [7:0] PAGE_DEFAULT = 8'h00;
    localparam logic [7:0] PAGE_CAN     = 8'h0c;

    // Control register field layout
    localparam int          CTRL_AUTO_BIT = 0;
    localparam logic [7:0]  CTRL_RESET    = 8'h01;

    // Addresses of the page-stack registers themselves (all-page)
    localparam logic [7:0] ADDR_PAGE_CTRL  = 8'h84;
    localparam logic [7:0] ADDR_CUR_PAGE   = 8'ha7;
    localparam logic [7:0] ADDR_STACK_PAGE = 8'h85;
    localparam logic [7:0] ADDR_BOTTOM     = 8'h86;

    // Port latches, reachable from every page
    localparam logic [7:0] ADDR_PORT0      = 8'h80;
    localparam logic [7:0] ADDR_PORT1      = 8'h90;
    localparam logic [7:0] ADDR_PORT2      = 8'ha0;
    localparam logic [7:0] ADDR_PORT3      = 8'hb0;

    // Bits of the control register that software can change
    localparam logic [7:0] CTRL_WR_MASK    = 8'h01;

    // Number of all-page addresses in the lookup table
    localparam int ALL_PAGE_N = 8;

    typedef struct packed {
        logic             wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0]       wdata;
    } sfr_acc_s;

    typedef struct packed {
        logic             enter;
        logic [PAGE_W-1:0] page;
    } irq_evt_s;

endpackage : page_stack_pkg

// ==== src/all_page_decode.sv ====
`timescale 1ns/10ps
`default_nettype none
module all_page_decode #(
    parameter int N = page_stack_pkg::ALL_PAGE_N
) (
    input  wire logic [page_stack_pkg::ADDR_W-1:0] addr,
    output logic                                   is_all_page
);
    // Port latches and the page-stack registers
    localparam logic [N*page_stack_pkg::ADDR_W-1:0] LIST = {
        page_stack_pkg::ADDR_PORT0, page_stack_pkg::ADDR_PORT1,
        page_stack_pkg::ADDR_PORT2, page_stack_pkg::ADDR_PORT3,
        page_stack_pkg::ADDR_PAGE_CTRL, page_stack_pkg::ADDR_CUR_PAGE,
        page_stack_pkg::ADDR_STACK_PAGE, page_stack_pkg::ADDR_BOTTOM
    };

    logic [N-1:0] hit;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_cmp
            assign hit[i] = (addr == LIST[i*page_stack_pkg::ADDR_W +: page_stack_pkg::ADDR_W]);
        end
    endgenerate

    assign is_all_page = |hit;
endmodule : all_page_decode
`default_nettype wire

// ==== src/sfr_page_stack.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfr_page_stack (
    input  wire logic                              clk,
    input  wire logic                              nrst,
    input  wire page_stack_pkg::sfr_acc_s          acc,
    input  wire logic                              acc_valid,
    input  wire page_stack_pkg::irq_evt_s          irq,
    input  wire logic                              irq_valid,
    input  wire logic                              reti,
    input  wire logic [page_stack_pkg::PAGE_W-1:0] reg_page,
    output logic                                   sel_hit,
    output logic [7:0]                             rdata,
    output logic                                   rdata_hit,
    output logic [page_stack_pkg::PAGE_W-1:0]      cur_page,
    output logic                                   auto_en
);
    typedef enum logic [1:0] {
        OP_IDLE,
        OP_PUSH,
        OP_POP
    } stack_op_e;

    // Control register and the three stack entries, top first
    logic [7:0]                        ctrl_ff;
    logic [page_stack_pkg::PAGE_W-1:0] cur_ff;
    logic [page_stack_pkg::PAGE_W-1:0] next_ff;
    logic [page_stack_pkg::PAGE_W-1:0] last_ff;
    logic [7:0]                        rdata_ff;
    logic                              rhit_ff;

    logic                              all_page;
    logic                              page_match;
    logic                              auto_on;
    logic                              irq_take;
    logic                              reti_take;
    stack_op_e                         op;
    logic                              stack_idle;

    logic                              sw_wr;
    logic                              sw_rd;
    logic                              hit_ctrl;
    logic                              hit_cur;
    logic                              hit_next;
    logic                              hit_last;
    logic                              hit_stack;
    logic                              wr_ctrl;
    logic                              wr_cur;
    logic                              wr_next;
    logic                              wr_last;
    logic [7:0]                        rd_mux;

    all_page_decode u_dec (
        .addr        (acc.addr),
        .is_all_page (all_page)
    );

    always_comb begin
        hit_ctrl = 1'h0;
        hit_cur  = 1'h0;
        hit_next = 1'h0;
        hit_last = 1'h0;
        rd_mux   = '0;
        case (acc.addr)
            page_stack_pkg::ADDR_PAGE_CTRL: begin
                hit_ctrl = 1'h1;
                rd_mux   = ctrl_ff;
            end
            page_stack_pkg::ADDR_CUR_PAGE: begin
                hit_cur = 1'h1;
                rd_mux  = cur_ff;
            end
            page_stack_pkg::ADDR_STACK_PAGE: begin
                hit_next = 1'h1;
                rd_mux   = next_ff;
            end
            page_stack_pkg::ADDR_BOTTOM: begin
                hit_last = 1'h1;
                rd_mux   = last_ff;
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    assign hit_stack = hit_ctrl || hit_cur || hit_next || hit_last;

    assign sw_wr = acc_valid && acc.wr;
    assign sw_rd = acc_valid && !acc.wr;

    assign irq_take  = irq_valid && irq.enter;
    assign reti_take = reti;
    assign auto_on   = ctrl_ff[page_stack_pkg::CTRL_AUTO_BIT];

    // An entry beats a return in the same cycle, since dropping the entry would lose its page
    always_comb begin
        op = OP_IDLE;
        if (auto_on) begin
            if (irq_take) begin
                op = OP_PUSH;
            end else if (reti_take) begin
                op = OP_POP;
            end
        end
    end

    assign stack_idle = op == OP_IDLE;

    // Stack entries ignore software in a push or pop cycle; the core never issues both
    always_comb begin
        wr_ctrl = 1'h0;
        wr_cur  = 1'h0;
        wr_next = 1'h0;
        wr_last = 1'h0;
        if (sw_wr) begin
            wr_ctrl = hit_ctrl;
            if (stack_idle) begin
                wr_cur  = hit_cur;
                wr_next = hit_next;
                wr_last = hit_last;
            end
        end
    end

    // Decoded against the live page register, so a page write shows on the next access
    assign page_match = reg_page == cur_ff;
    assign sel_hit    = acc_valid && (all_page || page_match);

    assign cur_page = cur_ff;
    assign auto_en  = auto_on;

    // Only the enable bit is kept; the other bits read back as zero
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= page_stack_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_ff <= acc.wdata & page_stack_pkg::CTRL_WR_MASK;
        end
    end

    // Stack motion beats a software write in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_ff <= page_stack_pkg::PAGE_DEFAULT;
        end else begin
            case (op)
                OP_PUSH: begin
                    cur_ff <= irq.page;
                end
                OP_POP: begin
                    cur_ff <= next_ff;
                end
                default: begin
                    if (wr_cur) begin
                        cur_ff <= acc.wdata;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            next_ff <= page_stack_pkg::PAGE_DEFAULT;
        end else begin
            case (op)
                OP_PUSH: begin
                    next_ff <= cur_ff;
                end
                OP_POP: begin
                    next_ff <= last_ff;
                end
                default: begin
                    if (wr_next) begin
                        next_ff <= acc.wdata;
                    end
                end
            endcase
        end
    end

    // Depth is three: the bottom entry is lost on a push from a full stack and kept on a pop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            last_ff <= page_stack_pkg::PAGE_DEFAULT;
        end else begin
            case (op)
                OP_PUSH: begin
                    last_ff <= next_ff;
                end
                default: begin
                    if (wr_last) begin
                        last_ff <= acc.wdata;
                    end
                end
            endcase
        end
    end

    // Read data stand until the next stack-register read, longer than the one-cycle hit strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= '0;
        end else if (sw_rd && hit_stack) begin
            rdata_ff <= rd_mux;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rhit_ff <= 1'h0;
        end else begin
            rhit_ff <= sw_rd && hit_stack;
        end
    end

    assign rdata     = rdata_ff;
    assign rdata_hit = rhit_ff;
endmodule : sfr_page_stack
`default_nettype wire

// ==== test/core_map.sv ====
`timescale 1ns/10ps
`default_nettype none
module core_map (
    input  wire logic [7:0] addr,
    output logic [7:0]      reg_page
);
    // Odd addresses on the CAN page, so both page outcomes occur
    assign reg_page = addr[0] ? page_stack_pkg::PAGE_CAN : page_stack_pkg::PAGE_DEFAULT;
endmodule : core_map
`default_nettype wire

// ==== test/sfr_page_stack_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module sfr_page_stack_props (
    input wire logic                     clk,
    input wire logic                     nrst,
    input wire logic                     acc_valid,
    input wire logic                     irq_valid,
    input wire logic                     reti,
    input wire logic                     sel_hit,
    input wire logic                     auto_en,
    input wire logic [7:0]               rdata,
    input wire logic [7:0]               cur_page,
    input wire page_stack_pkg::sfr_acc_s acc,
    input wire page_stack_pkg::irq_evt_s irq
);
    wire push = irq_valid && irq.enter && auto_en;
    wire rd = acc_valid && !acc.wr && !irq_valid && !reti;
    wire wr7 = acc_valid && acc.wr && acc.addr == 8'ha7 && !irq_valid && !reti;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    AST_CTRL: assert property (rd && acc.addr == 8'h84 |=> rdata == {7'h0, $past(auto_en)}) else $error("ctrl");
    AST_OFF: assert property (irq_valid && irq.enter && !auto_en && !acc_valid |=> $stable(cur_page)) else $error("off");
    AST_ALL: assert property (acc_valid && acc.addr == 8'h80 |-> sel_hit) else $error("all-page");
    AST_NEXT: assert property (push ##1 rd && acc.addr == 8'h85 |=> rdata == $past(cur_page, 2)) else $error("next");
    AST_PUSH: assert property (push |=> cur_page == $past(irq.page)) else $error("push");
    AST_WR: assert property (wr7 |=> cur_page == $past(acc.wdata)) else $error("write");
    AST_POP: assert property (push ##1 reti && auto_en && !irq_valid |=> cur_page == $past(cur_page, 2)) else $error("pop");
    cover property (push ##1 reti);
    cover property (rd && acc.addr == 8'h85);
    cover property (irq_valid && !auto_en);
endmodule : sfr_page_stack_props
bind sfr_page_stack sfr_page_stack_props i_props (.clk, .nrst, .acc_valid, .irq_valid, .reti, .sel_hit,
    .auto_en, .rdata, .cur_page, .acc, .irq);
`default_nettype wire

// ==== test/test_sfr_page_stack.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; $display("Error %0t %h %h", $time, a, b); end end
module test_sfr_page_stack;
    logic clk = 0, nrst = 0, acc_valid = 0, irq_valid = 0, reti = 0, sel_hit, rdata_hit, auto_en;
    logic [7:0] reg_page, rdata, cur_page, p, a;
    page_stack_pkg::sfr_acc_s acc = '0;
    page_stack_pkg::irq_evt_s irq = '0;
    int err_count = 0, n_compared = 0;
    always #25 clk = ~clk;
    core_map i_map (.addr(acc.addr), .reg_page);
    sfr_page_stack i_dut (.clk, .nrst, .acc, .acc_valid, .irq, .irq_valid, .reti, .reg_page,
        .sel_hit, .rdata, .rdata_hit, .cur_page, .auto_en);
    function automatic logic hit(logic [7:0] x, logic [7:0] c);
        return x inside {8'h80, 8'h90, 8'ha0, 8'hb0, 8'h84, 8'ha7, 8'h85, 8'h86} || (x[0] ? 8'h0c : 8'h00) == c;
    endfunction : hit
    // Held across the sampling edge, outputs read 1 ns later
    task automatic step(logic v, w, logic [7:0] ad, d, logic iv, rt, logic [7:0] pg);
        @(negedge clk) {acc_valid, acc, irq_valid, irq, reti} = {v, w, ad, d, iv, iv, pg, rt};
        @(posedge clk) #1;
    endtask : step
    task automatic finish_test;
        $display("errors %0d compared %0d", err_count, n_compared);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test
    initial begin
        void'($urandom(13));
        repeat (6) @(posedge clk);
        @(negedge clk) nrst = 1;
        `CHK(auto_en, 1'b1)
        step(0, 0, 0, 0, 1, 0, 8'h0c);
        `CHK(cur_page, 8'h0c)
        for (int i = 0; i < 24; i++) begin
            p = 8'($urandom) & 8'h0c;
            a = 8'($urandom) & 8'hb1;
            step(1, 1, 8'ha7, p, 0, 0, 0);
            step(1, 0, a, 0, 0, 0, 0);
            `CHK(sel_hit, hit(a, p))
            `CHK(rdata_hit, 1'b0)
        end
        step(0, 0, 0, 0, 1, 0, 8'h3c);
        step(0, 0, 0, 0, 0, 1, 0);
        step(0, 0, 0, 0, 1, 0, 8'h3c);
        step(1, 0, 8'h85, 0, 0, 0, 0);
        `CHK(rdata, p)
        `CHK(rdata_hit, 1'b1)
        step(0, 0, 0, 0, 0, 1, 0);
        step(0, 0, 0, 0, 0, 1, 0);
        `CHK(cur_page, 8'h00)
        step(1, 1, 8'h84, 0, 0, 0, 0);
        `CHK(auto_en, 1'b0)
        step(1, 0, 8'h84, 0, 0, 0, 0);
        `CHK(rdata, 8'h00)
        `CHK(rdata_hit, 1'b1)
        step(0, 0, 0, 0, 1, 0, 8'h3c);
        `CHK(cur_page, 8'h00)
        step(0, 0, 0, 0, 0, 0, 0);
        @(negedge clk) nrst = 0;
        repeat (2) @(negedge clk);
        nrst = 1;
        `CHK(auto_en, 1'b1)
        `CHK(cur_page, 8'h00)
        step(0, 0, 0, 0, 1, 0, 8'h0c);
        `CHK(cur_page, 8'h0c)
        finish_test();
    end
endmodule : test_sfr_page_stack
`default_nettype wire
